/* design/isa_row_b_pkg.sv */
/*
  Constants, command and state types for the expansion bus row B controller.
  Assumes a 50 MHz core clock; the bus clock arrives as a sampled input.
*/
package isa_row_b_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_NS = 20;
  localparam int REF_PERIOD_NS = 15600;
  localparam int REF_CYC_I = REF_PERIOD_NS / CLK_NS;
  localparam logic [9:0] REF_CYC = 10'(REF_CYC_I);
  localparam int RST_HOLD_NS = 2000;
  localparam logic [6:0] RST_CYC = 7'((RST_HOLD_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] BUS_WAIT_TICKS = 4'h4;
  localparam logic [3:0] REF_TICKS = 4'h4;
  localparam logic [3:0] ONE_TICK = 4'h1;
  localparam logic [3:0] LOW_MB_TOP = 4'h0;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  localparam int N_DMA = 4;
  localparam int N_IRQ = 6;
  localparam int LEN_W = 8;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {K_MEM_RD = 2'h0, K_MEM_WR = 2'h1, K_IO_RD = 2'h2, K_IO_WR = 2'h3} kind_t;

  typedef struct packed {
    kind_t kind;
    logic word;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } cmd_t;

  typedef enum logic [7:0] {
    S_IDLE = 8'h01, S_ALE = 8'h02, S_CMD = 8'h04, S_DONE = 8'h08,
    S_REF = 8'h10, S_DMA = 8'h20, S_DEND = 8'h40, S_MST = 8'h80
  } fsm_t;
endpackage

/* design/isa_row_b_ctrl.sv */
/*
  Board-side controller for the control row of a stacked ISA-style bus:
  reset drive, refresh, processor cycles from a two-entry command buffer,
  single DMA transfers and bus-master hand-over, terminal count.
  Assumes every pin input is asynchronous to CLOCK and the bus clock is
  sampled by CLOCK; user-side ports are synchronous to CLOCK.
*/
// How it works
// - Reset drive high at power-up and reset
// - DMA channel may hand bus to master
// - Active-low acknowledge selects the requesting card
// - Zero-wait response ends cycle at once
// - Legacy memory strobes only below 1MB
// - Owner drives I/O write strobe with data
// - Owner drives I/O read; card drives data
// - Refresh low whole cycle, every 15.6 us
// - Free-running bus clock supplied to cards
// - One terminal count pulse at last transfer
// - Cards latch upper address on latch fall
// - Latch enable held high during DMA
// - Oscillator output unrelated to bus clock
// - Byte-high enable low for upper-lane transfers
`timescale 1ns/1ps

module isa_row_b_ctrl (
  input wire logic CLOCK,                                        // core clock 50 MHz
  input wire logic RST_B,                                        // async reset
  input wire logic SYS_RESET_B,                                  // system reset request pin
  input wire logic SYSCLK_IN,                                    // bus clock source
  input wire logic OSC_IN,                                       // oscillator source
  input wire logic [isa_row_b_pkg::N_DMA-1:0] DRQ,               // DMA request pins
  input wire logic ZWS_B,                                        // zero wait state pin
  input wire logic [isa_row_b_pkg::N_IRQ-1:0] IRQ,               // interrupt request pins
  input wire logic [isa_row_b_pkg::DATA_W-1:0] SD_I,             // data bus in
  input wire logic CMD_VALID,                                    // command offered
  input wire isa_row_b_pkg::kind_t CMD_KIND,                     // command kind
  input wire logic CMD_WORD,                                     // 16-bit transfer
  input wire logic [isa_row_b_pkg::ADDR_W-1:0] CMD_ADDR,         // command address
  input wire logic [isa_row_b_pkg::DATA_W-1:0] CMD_DATA,         // write data
  input wire logic RD_READY,                                     // read data taken
  input wire logic [isa_row_b_pkg::LEN_W-1:0] DMA_LEN,           // terminal transfer index
  input wire logic [isa_row_b_pkg::ADDR_W-1:0] DMA_ADDR,         // DMA memory address
  input wire logic [isa_row_b_pkg::N_DMA-1:0] MASTER_EN,         // channel serves a bus master
  output logic CMD_READY,                                        // buffer has room
  output logic RD_VALID,                                         // read data valid
  output logic [isa_row_b_pkg::DATA_W-1:0] RD_DATA,              // read data
  output logic RSTDRV,                                           // bus reset drive
  output logic SYSCLK,                                           // bus clock out
  output logic OSC,                                              // oscillator out
  output logic BALE,                                             // address latch enable
  output logic IOR_B,                                            // I/O read strobe
  output logic IOW_B,                                            // I/O write strobe
  output logic SMEMR_B,                                          // legacy memory read
  output logic SMEMW_B,                                          // legacy memory write
  output logic REFRESH_B,                                        // refresh in progress
  output logic [isa_row_b_pkg::N_DMA-1:0] DACK_B,                // DMA acknowledges
  output logic TC,                                               // terminal count
  output logic SBHE_B,                                           // byte high enable
  output logic [19:0] SA,                                        // system address
  output logic [6:0] LA,                                         // latchable address 23..17
  output logic [isa_row_b_pkg::DATA_W-1:0] SD_O,                 // data bus out
  output logic SD_OE_B,                                          // data bus enable, low drives
  output logic CTL_OE_B,                                         // strobe/address enable, low drives
  output logic [isa_row_b_pkg::N_IRQ-1:0] IRQ_PEND               // synchronised requests
);
  import isa_row_b_pkg::*;

  typedef struct packed {
    logic srst_s1, srst_s2, clk_s1, clk_s2, clk_d, osc_s1, osc_s2, zws_s1, zws_s2;
    logic [N_DMA-1:0] drq_s1, drq_s2;
    logic [N_IRQ-1:0] irq_s1, irq_s2, irq;
    logic [DATA_W-1:0] sd_s1, sd_s2;
    logic [6:0] rst_cnt;
    logic rstdrv, sysclk, osc;
    cmd_t [1:0] q;
    logic wp, rp, cmd_rdy;
    logic [1:0] cnt;
    fsm_t fsm;
    cmd_t cur;
    logic [3:0] ticks;
    logic [1:0] dma_ch;
    logic [N_DMA-1:0][LEN_W-1:0] dma_cnt;
    logic [9:0] ref_cnt;
    logic ref_due;
    logic [7:0] ref_row;
    logic bale, ior_b, iow_b, smemr_b, smemw_b, refresh_b, tc, sbhe_b, sd_oe_b, ctl_oe_b, rd_valid;
    logic [N_DMA-1:0] dack_b;
    logic [19:0] sa;
    logic [6:0] la;
    logic [DATA_W-1:0] sd_o, rd_data;
  } state_t;

  // Request stages start asserted so the reset drive hold is re-armed after release
  localparam state_t ST_INIT = '{fsm: S_IDLE, srst_s1: 1'b0, srst_s2: 1'b0, zws_s1: 1'b1, zws_s2: 1'b1,
    rstdrv: 1'b1, cmd_rdy: 1'b1, ior_b: 1'b1, iow_b: 1'b1, smemr_b: 1'b1, smemw_b: 1'b1,
    refresh_b: 1'b1, sbhe_b: 1'b1, sd_oe_b: 1'b1, dack_b: '1, default: '0};

  state_t r, n;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic tick, push, pop, found, low;
    logic [1:0] ch;
    tick = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    found = 1'b0;
    low = 1'b0;
    ch = 2'h0;
    n = r;
    // Two stages on every pin before use
    n.srst_s1 = SYS_RESET_B;
    n.srst_s2 = r.srst_s1;
    n.clk_s1 = SYSCLK_IN;
    n.clk_s2 = r.clk_s1;
    n.clk_d = r.clk_s2;
    n.osc_s1 = OSC_IN;
    n.osc_s2 = r.osc_s1;
    n.zws_s1 = ZWS_B;
    n.zws_s2 = r.zws_s1;
    n.drq_s1 = DRQ;
    n.drq_s2 = r.drq_s1;
    n.irq_s1 = IRQ;
    n.irq_s2 = r.irq_s1;
    n.sd_s1 = SD_I;
    n.sd_s2 = r.sd_s1;
    n.irq = r.irq_s2;
    tick = r.clk_s2 & ~r.clk_d;
    n.sysclk = r.clk_s2;
    n.osc = r.osc_s2;

    // Reset drive: held while requested and a minimum time after
    if (!r.srst_s2) begin
      n.rst_cnt = RST_CYC;
      n.rstdrv = 1'b1;
    end else if (r.rst_cnt != 7'h00) begin
      n.rst_cnt = r.rst_cnt - 7'h01;
    end else begin
      n.rstdrv = 1'b0;
    end

    if (r.rd_valid && RD_READY) begin
      n.rd_valid = 1'b0;
    end

    for (int i = N_DMA - 1; i >= 0; i--) begin
      if (r.drq_s2[i]) begin
        found = 1'b1;
        ch = 2'(i);
      end
    end

    case (r.fsm)
      S_IDLE: begin
        // Refresh first, then DMA, then queued processor cycles
        if (!r.rstdrv && tick) begin
          if (r.ref_due) begin
            n.ref_due = 1'b0;
            n.refresh_b = 1'b0;
            n.smemr_b = 1'b0;
            n.la = 7'h00;
            n.sa = {12'h000, r.ref_row};
            n.ref_row = r.ref_row + 8'h01;
            n.ticks = REF_TICKS;
            n.fsm = S_REF;
          end else if (found) begin
            n.dma_ch = ch;
            n.dack_b[ch] = 1'b0;
            n.bale = 1'b1;
            if (MASTER_EN[ch]) begin
              n.ctl_oe_b = 1'b1;
              n.fsm = S_MST;
            end else begin
              low = DMA_ADDR[23:20] == LOW_MB_TOP;
              n.sa = DMA_ADDR[19:0];
              n.la = DMA_ADDR[23:17];
              n.ior_b = 1'b0;
              n.smemw_b = ~low;
              n.ticks = BUS_WAIT_TICKS;
              n.fsm = S_DMA;
            end
          end else if (r.cnt != 2'h0) begin
            pop = 1'b1;
            n.cur = r.q[r.rp];
            n.sa = r.q[r.rp].addr[19:0];
            n.la = r.q[r.rp].addr[23:17];
            n.sbhe_b = ~(r.q[r.rp].word | r.q[r.rp].addr[0]);
            n.bale = 1'b1;
            n.fsm = S_ALE;
          end
        end
      end
      S_ALE: begin
        if (tick) begin
          low = r.cur.addr[23:20] == LOW_MB_TOP;
          n.bale = 1'b0;
          n.ticks = BUS_WAIT_TICKS;
          n.fsm = S_CMD;
          case (r.cur.kind)
            K_MEM_RD: n.smemr_b = ~low;
            K_MEM_WR: begin
              n.smemw_b = ~low;
              n.sd_o = r.cur.data;
              n.sd_oe_b = 1'b0;
            end
            K_IO_RD: n.ior_b = 1'b0;
            default: begin
              n.iow_b = 1'b0;
              n.sd_o = r.cur.data;
              n.sd_oe_b = 1'b0;
            end
          endcase
        end
      end
      S_CMD: begin
        if (tick) begin
          // Zero-wait answer ends the cycle at this bus clock edge
          if (!r.zws_s2 || r.ticks == ONE_TICK) begin
            n.ior_b = 1'b1;
            n.iow_b = 1'b1;
            n.smemr_b = 1'b1;
            n.smemw_b = 1'b1;
            n.sd_oe_b = 1'b1;
            n.sbhe_b = 1'b1;
            n.cur.data = r.sd_s2;
            n.fsm = S_DONE;
          end else begin
            n.ticks = r.ticks - ONE_TICK;
          end
        end
      end
      S_DONE: begin
        // Read result waits here while the output slot is full
        if (r.cur.kind == K_MEM_RD || r.cur.kind == K_IO_RD) begin
          if (!r.rd_valid) begin
            n.rd_valid = 1'b1;
            n.rd_data = r.cur.data;
            n.fsm = S_IDLE;
          end
        end else begin
          n.fsm = S_IDLE;
        end
      end
      S_REF: begin
        if (tick) begin
          if (r.ticks == ONE_TICK) begin
            n.refresh_b = 1'b1;
            n.smemr_b = 1'b1;
            n.fsm = S_IDLE;
          end else begin
            n.ticks = r.ticks - ONE_TICK;
          end
        end
      end
      S_DMA: begin
        if (tick) begin
          if (r.ticks == ONE_TICK) begin
            n.ior_b = 1'b1;
            n.smemw_b = 1'b1;
            n.dack_b = '1;
            n.bale = 1'b0;
            if (r.dma_cnt[r.dma_ch] == DMA_LEN) begin
              n.dma_cnt[r.dma_ch] = '0;
              n.tc = 1'b1;
            end else begin
              n.dma_cnt[r.dma_ch] = r.dma_cnt[r.dma_ch] + 8'h01;
            end
            n.fsm = S_DEND;
          end else begin
            n.ticks = r.ticks - ONE_TICK;
          end
        end
      end
      S_DEND: begin
        if (tick) begin
          n.tc = 1'b0;
          n.fsm = S_IDLE;
        end
      end
      S_MST: begin
        // Master owns strobes and address until it drops its request
        if (!r.drq_s2[r.dma_ch]) begin
          n.dack_b = '1;
          n.bale = 1'b0;
          n.ctl_oe_b = 1'b0;
          n.fsm = S_IDLE;
        end
      end
      default: n.fsm = S_IDLE;
    endcase

    // Counter sets after the state machine clears, so a due never gets lost
    if (r.ref_cnt == REF_CYC - 10'h001) begin
      n.ref_cnt = 10'h000;
      n.ref_due = 1'b1;
    end else begin
      n.ref_cnt = r.ref_cnt + 10'h001;
    end

    push = CMD_VALID & r.cmd_rdy;
    if (push) begin
      n.q[r.wp] = '{kind: CMD_KIND, word: CMD_WORD, addr: CMD_ADDR, data: CMD_DATA};
      n.wp = ~r.wp;
    end
    if (pop) begin
      n.rp = ~r.rp;
    end
    n.cnt = r.cnt + {1'b0, push} - {1'b0, pop};
    n.cmd_rdy = n.cnt != 2'h2;
  end

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      r <= ST_INIT;
    end else begin
      r <= n;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign CMD_READY = r.cmd_rdy;
  assign RD_VALID = r.rd_valid;
  assign RD_DATA = r.rd_data;
  assign RSTDRV = r.rstdrv;
  assign SYSCLK = r.sysclk;
  assign OSC = r.osc;
  assign BALE = r.bale;
  assign IOR_B = r.ior_b;
  assign IOW_B = r.iow_b;
  assign SMEMR_B = r.smemr_b;
  assign SMEMW_B = r.smemw_b;
  assign REFRESH_B = r.refresh_b;
  assign DACK_B = r.dack_b;
  assign TC = r.tc;
  assign SBHE_B = r.sbhe_b;
  assign SA = r.sa;
  assign LA = r.la;
  assign SD_O = r.sd_o;
  assign SD_OE_B = r.sd_oe_b;
  assign CTL_OE_B = r.ctl_oe_b;
  assign IRQ_PEND = r.irq;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_B);

  property p_rstdrv;
    !r.srst_s2 |=> r.rstdrv [*8];
  endproperty
  a_rstdrv: assert property (p_rstdrv) else $error("reset drive not held");

  property p_dack_cause;
    ($past(r.dack_b) == '1 && r.dack_b != '1) |-> (($past(r.drq_s2) & ~r.dack_b) != '0) && $onehot(~r.dack_b);
  endproperty
  a_dack_cause: assert property (p_dack_cause) else $error("acknowledge without request");

  property p_master;
    (r.fsm == S_MST) |-> r.ctl_oe_b && !r.dack_b[r.dma_ch];
  endproperty
  a_master: assert property (p_master) else $error("bus not handed to master");

  property p_zws;
    (r.fsm == S_CMD && (r.clk_s2 & ~r.clk_d) && !r.zws_s2) |=> r.ior_b && r.iow_b && r.smemr_b && r.smemw_b;
  endproperty
  a_zws: assert property (p_zws) else $error("zero wait cycle not ended");

  property p_low_mb;
    (!r.smemr_b || !r.smemw_b) |-> r.la[6:3] == LOW_MB_TOP;
  endproperty
  a_low_mb: assert property (p_low_mb) else $error("legacy strobe above 1MB");

  property p_iow;
    $fell(r.iow_b) |-> !r.sd_oe_b && r.sd_o == r.cur.data;
  endproperty
  a_iow: assert property (p_iow) else $error("write strobe without data");

  property p_ior;
    !r.ior_b |-> r.sd_oe_b;
  endproperty
  a_ior: assert property (p_ior) else $error("data driven during read");

  property p_refresh;
    $fell(r.refresh_b) |-> !r.smemr_b ##1 !r.refresh_b [*4];
  endproperty
  a_refresh: assert property (p_refresh) else $error("refresh cycle too short");

  property p_tc;
    $rose(r.tc) |-> r.fsm == S_DEND ##[1:400] !r.tc;
  endproperty
  a_tc: assert property (p_tc) else $error("terminal count not a pulse");

  property p_bale_dma;
    (r.dack_b != '1) |-> r.bale;
  endproperty
  a_bale_dma: assert property (p_bale_dma) else $error("latch enable low in DMA");

  property p_sbhe;
    (r.fsm == S_CMD && r.cur.word) |-> !r.sbhe_b;
  endproperty
  a_sbhe: assert property (p_sbhe) else $error("byte high enable missing");

  c_refresh: cover property ($rose(r.refresh_b));
  c_tc: cover property ($rose(r.tc));
  c_zws: cover property (r.fsm == S_CMD && !r.zws_s2 ##1 r.fsm == S_DONE);
  c_master: cover property ($rose(r.ctl_oe_b));
endmodule

/* bench/isa_card_model.sv */
/*
  Behavioural expansion card facing the row B controller: I/O and memory slave
  with optional zero-wait answer, DMA requester and bus-master requester.
  Assumes the bench changes its controls just after a falling CLOCK edge.
*/
`timescale 1ns/1ps

module isa_card_model (
  input wire logic clk,              // core clock
  input wire logic rst_b,            // reset, active low
  input wire logic ior_b,            // I/O read strobe
  input wire logic iow_b,            // I/O write strobe
  input wire logic smemr_b,          // legacy memory read
  input wire logic smemw_b,          // legacy memory write
  input wire logic sd_oe_b,          // board drives data when low
  input wire logic [15:0] sd_o,      // board data
  input wire logic [3:0] dack_b,     // acknowledges
  input wire logic fast,             // decode answers zero-wait
  input wire logic [15:0] rd_val,    // data returned on reads
  input wire logic [3:0] req,        // one-cycle request pulses
  input wire logic [3:0] hold,       // keep request past acknowledge
  output logic [15:0] sd_i,          // data seen by board
  output logic zws_b,                // zero wait answer
  output logic [3:0] drq,            // DMA requests
  output logic [15:0] wr_seen        // last data written
);
  logic [15:0] last_r;
  logic rd_on;

  // ----------------------------------------------------------------
  // Slave side
  // ----------------------------------------------------------------
  assign rd_on = !ior_b || !smemr_b;
  // Released bus shows the inverse of its last level, never a stale copy
  assign sd_i = rd_on ? rd_val : (!sd_oe_b ? sd_o : ~last_r);
  assign zws_b = !(fast && (rd_on || !iow_b || !smemw_b));

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      last_r <= 16'h0000;
      drq <= 4'h0;
      wr_seen <= 16'h0000;
    end else begin
      if (rd_on || !sd_oe_b) begin
        last_r <= sd_i;
      end
      if (!sd_oe_b && (!iow_b || !smemw_b)) begin
        wr_seen <= sd_o;
      end
      drq <= (drq | req) & ~(~dack_b & ~hold);
    end
  end
endmodule

/* bench/isa_row_b_ctrl_tb.sv */
/*
  Self-checking bench for the row B controller with a card model on the bus.
  Assumes 50 MHz CLOCK, a 160 ns bus clock source and a 70 ns oscillator.
*/
`timescale 1ns/1ps

module isa_row_b_ctrl_tb;
  import isa_row_b_pkg::*;
  typedef struct packed {kind_t k; logic w; logic f; logic [23:0] a; logic [15:0] d; logic [3:0] m; logic hb;} row_t;
  // Strobe mask order: IOR, IOW, SMEMR, SMEMW
  localparam row_t ROWS [6] = '{
    '{K_IO_WR, 1'b1, 1'b0, 24'h000300, 16'hA55A, 4'h4, 1'b0},
    '{K_IO_RD, 1'b0, 1'b1, 24'h000301, 16'h1234, 4'h8, 1'b0},
    '{K_MEM_RD, 1'b1, 1'b0, 24'h0C0000, 16'hBEEF, 4'h2, 1'b0},
    '{K_MEM_WR, 1'b0, 1'b1, 24'h0FFFFE, 16'h00C3, 4'h1, 1'b1},
    '{K_MEM_WR, 1'b1, 1'b0, 24'h100000, 16'h5AA5, 4'h0, 1'b0},
    '{K_MEM_RD, 1'b0, 1'b0, 24'hE20000, 16'h0F0F, 4'h0, 1'b1}};
  logic CLOCK = 0, RST_B = 0, SYS_RESET_B = 1, SYSCLK_IN = 0, OSC_IN = 0, CMD_VALID = 0, CMD_WORD = 0;
  logic RD_READY = 0, fast = 0, ZWS_B, CMD_READY, RD_VALID, RSTDRV, SYSCLK, OSC, BALE, IOR_B, IOW_B;
  logic SMEMR_B, SMEMW_B, REFRESH_B, TC, SBHE_B, SD_OE_B, CTL_OE_B, hb_seen, full_seen;
  logic p_tc, p_iow, p_ref, p_osc, p_osci, p_sc, p_sci;
  logic [3:0] DRQ, DACK_B, mask, MASTER_EN = 0, req = 0, hold = 0;
  logic [5:0] IRQ = 0, IRQ_PEND;
  logic [15:0] SD_I, SD_O, RD_DATA, wr_seen, CMD_DATA = 0, rd_val = 0;
  logic [23:0] CMD_ADDR = 0, DMA_ADDR = 24'h000400;
  logic [7:0] DMA_LEN = 0;
  logic [19:0] SA;
  logic [6:0] LA, la_seen;
  kind_t CMD_KIND = K_MEM_RD;
  int miscompares = 0, check_count = 0, cyc = 0, slow_n, tc_n = 0, iow_n = 0, ref_t = 0, ref_d = 0;
  int ref_n = 0, ref_bad = 0, osc_d = 0, clk_d = 0;

  isa_row_b_ctrl dut_u (.CLOCK(CLOCK), .RST_B(RST_B), .SYS_RESET_B(SYS_RESET_B), .SYSCLK_IN(SYSCLK_IN),
    .OSC_IN(OSC_IN), .DRQ(DRQ), .ZWS_B(ZWS_B), .IRQ(IRQ), .SD_I(SD_I), .CMD_VALID(CMD_VALID),
    .CMD_KIND(CMD_KIND), .CMD_WORD(CMD_WORD), .CMD_ADDR(CMD_ADDR), .CMD_DATA(CMD_DATA), .RD_READY(RD_READY),
    .DMA_LEN(DMA_LEN), .DMA_ADDR(DMA_ADDR), .MASTER_EN(MASTER_EN), .CMD_READY(CMD_READY), .RD_VALID(RD_VALID),
    .RD_DATA(RD_DATA), .RSTDRV(RSTDRV), .SYSCLK(SYSCLK), .OSC(OSC), .BALE(BALE), .IOR_B(IOR_B), .IOW_B(IOW_B),
    .SMEMR_B(SMEMR_B), .SMEMW_B(SMEMW_B), .REFRESH_B(REFRESH_B), .DACK_B(DACK_B), .TC(TC), .SBHE_B(SBHE_B),
    .SA(SA), .LA(LA), .SD_O(SD_O), .SD_OE_B(SD_OE_B), .CTL_OE_B(CTL_OE_B), .IRQ_PEND(IRQ_PEND));

  isa_card_model card_u (.clk(CLOCK), .rst_b(RST_B), .ior_b(IOR_B), .iow_b(IOW_B), .smemr_b(SMEMR_B),
    .smemw_b(SMEMW_B), .sd_oe_b(SD_OE_B), .sd_o(SD_O), .dack_b(DACK_B), .fast(fast), .rd_val(rd_val),
    .req(req), .hold(hold), .sd_i(SD_I), .zws_b(ZWS_B), .drq(DRQ), .wr_seen(wr_seen));

  // ----------------------------------------------------------------
  // Clocks, monitor and helpers
  // ----------------------------------------------------------------
  initial forever #10 CLOCK = ~CLOCK;
  initial begin
    #7;
    forever #80 SYSCLK_IN = ~SYSCLK_IN;
  end
  initial forever #35 OSC_IN = ~OSC_IN;

  always @(negedge CLOCK) begin
    cyc++;
    if (TC && !p_tc) tc_n++;
    if (!IOW_B && p_iow) iow_n++;
    if (!REFRESH_B && p_ref) begin
      ref_d = cyc - ref_t;
      ref_t = cyc;
      ref_n = 0;
    end
    if (!REFRESH_B) begin
      ref_n++;
      if (SMEMR_B !== 1'b0) ref_bad++;
    end else begin
      mask |= ~{IOR_B, IOW_B, SMEMR_B, SMEMW_B};
      if (!(IOR_B && IOW_B && SMEMR_B && SMEMW_B)) slow_n++;
      if (BALE) begin
        hb_seen = SBHE_B;
        la_seen = LA;
      end
    end
    if (OSC && !p_osc) osc_d++;
    if (OSC_IN && !p_osci) osc_d--;
    if (SYSCLK && !p_sc) clk_d++;
    if (SYSCLK_IN && !p_sci) clk_d--;
    if (CMD_READY === 1'b0) full_seen = 1;
    {p_tc, p_iow, p_ref, p_osc, p_osci, p_sc, p_sci} = {TC, IOW_B, REFRESH_B, OSC, OSC_IN, SYSCLK, SYSCLK_IN};
  end

  task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic test_done;
    $display("Checks %0d, miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Holds the offer until an edge samples CMD_READY high
  task automatic push(input kind_t k, input logic w, input logic [23:0] a, input logic [15:0] d);
    int n;
    @(negedge CLOCK);
    {CMD_VALID, CMD_KIND, CMD_WORD, CMD_ADDR, CMD_DATA} = {1'b1, k, w, a, d};
    n = 0;
    do begin
      @(posedge CLOCK);
      n++;
    end while (CMD_READY !== 1'b1 && n < 500);
  endtask

  task automatic wait_for(input int lim, ref logic sig, input logic lvl);
    int n;
    n = 0;
    while (sig !== lvl && n < lim) begin
      @(negedge CLOCK);
      n++;
    end
  endtask

  initial begin
    #400000;
    miscompares++;
    test_done();
  end

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    int t0;
    repeat (5) @(negedge CLOCK);
    chk("rstdrv_in_reset", RSTDRV, 1'b1);
    chk("reset_outputs", {CMD_READY, IOR_B, IOW_B, SMEMR_B, SMEMW_B, REFRESH_B, DACK_B, BALE, TC}, 12'hFFC);
    RST_B = 1;
    repeat (90) @(negedge CLOCK);
    chk("rstdrv_hold", RSTDRV, 1'b1);
    wait_for(40, RSTDRV, 1'b0);
    chk("rstdrv_release", RSTDRV, 1'b0);
    osc_d = 0;
    clk_d = 0;
    foreach (ROWS[i]) begin
      rd_val = ROWS[i].d;
      fast = ROWS[i].f;
      push(ROWS[i].k, ROWS[i].w, ROWS[i].a, ROWS[i].d);
      @(negedge CLOCK);
      CMD_VALID = 0;
      mask = 0;
      slow_n = 0;
      repeat (130) @(negedge CLOCK);
      chk("strobes", mask, ROWS[i].m);
      chk("byte_high", hb_seen, ROWS[i].hb);
      chk("latch_addr", la_seen, ROWS[i].a[23:17]);
      if (ROWS[i].m != 0) chk("strobe_len", ROWS[i].f ? slow_n <= 16 : slow_n >= 31 && slow_n <= 33, 1'b1);
      if (ROWS[i].m[2] || ROWS[i].m[0]) chk("wr_data", wr_seen, ROWS[i].d);
      if (ROWS[i].k == K_MEM_RD || ROWS[i].k == K_IO_RD) begin
        chk("rd_valid", RD_VALID, 1'b1);
        if (ROWS[i].m != 0) chk("rd_data", RD_DATA, ROWS[i].d);
        RD_READY = 1;
        @(negedge CLOCK);
        RD_READY = 0;
        @(negedge CLOCK);
        chk("rd_taken", RD_VALID, 1'b0);
      end
    end
    // Back-to-back writes fill the buffer until it refuses
    full_seen = 0;
    t0 = iow_n;
    for (int j = 0; j < 4; j++) push(K_IO_WR, 1'b1, {22'h0000C4, j[1:0]}, {14'h3000, j[1:0]});
    @(negedge CLOCK);
    CMD_VALID = 0;
    repeat (400) @(negedge CLOCK);
    chk("buffer_full", full_seen, 1'b1);
    chk("write_count", 24'(iow_n - t0), 24'h4);
    chk("last_write", wr_seen, 16'hC003);
    for (int c = 0; c < 4; c++) begin
      t0 = tc_n;
      req[c] = 1;
      @(negedge CLOCK);
      req = 0;
      for (int k = 0; k < 200 && DACK_B[c] !== 1'b0; k++) @(negedge CLOCK);
      @(negedge CLOCK);
      chk("dack", DACK_B ^ 4'hF, 4'h1 << c);
      chk("dma_strobes", {BALE, IOR_B, SMEMW_B}, 3'b100);
      repeat (60) @(negedge CLOCK);
      chk("tc_pulse", 24'(tc_n - t0), 24'h1);
      chk("dma_done", DACK_B, 4'hF);
    end
    MASTER_EN = 4'h8;
    hold = 4'h8;
    req = 4'h8;
    @(negedge CLOCK);
    req = 0;
    for (int k = 0; k < 200 && DACK_B[3] !== 1'b0; k++) @(negedge CLOCK);
    repeat (20) @(negedge CLOCK);
    chk("master_owns", {CTL_OE_B, DACK_B[3], BALE}, 3'b101);
    hold = 0;
    wait_for(20, CTL_OE_B, 1'b0);
    chk("master_done", {CTL_OE_B, DACK_B[3]}, 2'b01);
    MASTER_EN = 0;
    IRQ = 6'h2A;
    repeat (5) @(negedge CLOCK);
    chk("irq_pend", IRQ_PEND, 6'h2A);
    IRQ = 0;
    repeat (1700) @(negedge CLOCK);
    chk("ref_period", ref_d >= 772 && ref_d <= 792, 1'b1);
    chk("ref_len", ref_n >= 31 && ref_n <= 33, 1'b1);
    chk("ref_smemr", 24'(ref_bad), 24'h0);
    chk("osc_follow", osc_d >= -1 && osc_d <= 1, 1'b1);
    chk("sysclk_follow", clk_d >= -1 && clk_d <= 1, 1'b1);
    SYS_RESET_B = 0;
    repeat (3) @(negedge CLOCK);
    SYS_RESET_B = 1;
    repeat (4) @(negedge CLOCK);
    chk("rstdrv_rearm", RSTDRV, 1'b1);
    wait_for(130, RSTDRV, 1'b0);
    chk("rstdrv_rearm_end", RSTDRV, 1'b0);
    test_done();
  end
endmodule
